// [pin_mux_pkg.sv]
// Constants, variants and carrier types for the pin-function mux.
// Assumes an APB master with 32-bit data and a 12-bit byte address.
`default_nettype none

package pin_mux_pkg;

    // Device variants; the reduced and single-bit ones have fewer implemented bits
    typedef enum logic [1:0] {
        VARIANT_FULL,
        VARIANT_REDUCED,
        VARIANT_SMALLEST,
        VARIANT_SINGLE_BIT
    } variant_e;

    // Register byte offsets
    localparam logic [11:0] OFS_PORT_E = 12'h000;
    localparam logic [11:0] OFS_PORT_F = 12'h004;
    localparam logic [11:0] OFS_PORT_G = 12'h008;
    localparam logic [11:0] OFS_PORT_H = 12'h00C;
    localparam logic [11:0] OFS_SPECIAL = 12'h010;
    localparam logic [11:0] OFS_SPECIAL_TWO = 12'h014;
    localparam logic [11:0] OFS_PORT_B = 12'h018;

    // Values after reset and implemented-bit masks
    localparam logic [7:0] RST_PORT_FS = 8'hFF;
    localparam logic [7:0] RST_SPECIAL = 8'h00;
    localparam logic [7:0] RST_SPECIAL_TWO = 8'h00;
    localparam logic [7:0] RST_PORT_B = 8'h00;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_PORT_H_REDUCED = 8'h0F;
    localparam logic [7:0] MASK_SPECIAL_TWO = 8'h3F;
    localparam logic [7:0] MASK_SPECIAL_TWO_SINGLE = 8'h07;
    localparam logic [7:0] MASK_PORT_B = 8'hF0;

    // Field positions in the special route register
    localparam int unsigned STD_TIMER_CLK_ROUTE_BIT = 7;
    localparam int unsigned PTIMER0_CLK_ROUTE_BIT = 6;
    localparam int unsigned COMPACT_TIMER_CLK_ROUTE_BIT = 5;
    localparam int unsigned EXT_IRQ1_ROUTE_BIT = 4;

    // Field positions in the second special route register
    localparam int unsigned PORTA_LINE4_SELECT = 5;
    localparam int unsigned PORTB_LINE4_HIGH_SELECT = 4;
    localparam int unsigned PORTB_LINE5_HIGH_SELECT = 3;
    localparam int unsigned PORTB_LINE7_LOW_SELECT = 2;
    localparam int unsigned PORTB_LINE6_LOW_SELECT = 1;
    localparam int unsigned PTIMER1_CLK_ROUTE_BIT = 0;

    // Pad levels read back from the shared pins
    typedef struct packed {
        logic pb6;
        logic pd3;
        logic pd2;
        logic pd1;
        logic pd0;
        logic pa4;
        logic pa2;
        logic pa0;
    } pad_in_s;

    // Timer outputs offered to the pins
    typedef struct packed {
        logic periodic_timer1_out_inv;
        logic periodic_timer1_out;
        logic periodic_timer0_out_inv;
        logic periodic_timer0_out;
        logic compact_timer_out_two;
    } timer_out_s;

    // Routed inputs handed to the peripherals
    typedef struct packed {
        logic standard_timer_ext_clock;
        logic periodic_timer0_ext_clock;
        logic periodic_timer1_ext_clock;
        logic compact_timer_ext_clock;
        logic external_irq_line_one;
        logic external_irq_line_zero;
        logic uart_rx;
    } periph_in_s;

    // Analog connections of the shared pins
    typedef struct packed {
        logic analog_input_five;
        logic analog_input_zero;
        logic analog_input_one;
        logic analog_input_two;
        logic adc_reference_input;
        logic adc_reference_output;
    } analog_en_s;

endpackage

`default_nettype wire

// [pin_function_select_mux.sv]
// Pin-function mux for ports E to H, port D specials, port B and PA4.
// Assumes an APB master on i_clock and pads outside this clock domain.
//
// What this block does
// - Port E select bit 1 gives segment 15..8 on lines 7..0, else GPIO.
// - Port F select bit 1 gives segment 23..16 on lines 7..0, else GPIO.
// - Port G select bit 1 gives segment 31..24 on lines 7..0, else GPIO.
// - Port H select bit 1 gives segment 39..32 on lines 7..0, else GPIO.
// - Reduced variant keeps port H bits 3..0 only; upper bits read zero.
// - Route bit 7 takes standard timer clock from PA2 or PD2; smallest variant always PA2.
// - Route bit 6 takes periodic timer 0 clock from PA0 or PD3.
// - Route bit 5 takes compact timer clock from PA2 or PD1.
// - Route bit 4 takes external interrupt one from PA0 or PD0.
// - Route bits 3..0 put timer outputs instead of segments on PD7..PD4.
// - Smallest variant: route bit 7 puts compact output two on PD2.
// - Second route bit 0 takes periodic timer 1 clock from PA4 or PD0.
// - Second route bit 5 makes PA4 analog input five, else digital.
// - PB4 code 00 GPIO, 01 timer 0, 10 reference in, 11 GPIO.
// - PB5 code 00 GPIO, 01 timer 0 inverted, 10 reference out, 11 AN0.
// - PB7 code 00 GPIO, 01 AN2, 10 timer 1 inverted, 11 UART transmit.
// - PB6 code 00 GPIO, 01 AN1, 10 timer 1, 11 UART receive.
// - Single-bit variant chooses timer 1 outputs or UART on PB7, PB6.
// - Second route register bits 7 and 6 always read zero.
// - Port B select bits 7..4 reset to zero and pair with route bits.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pin_function_select_mux #(
    parameter pin_mux_pkg::variant_e VARIANT = pin_mux_pkg::VARIANT_FULL
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Pads and peripheral sources
    input wire pin_mux_pkg::pad_in_s i_pad_in,
    input wire logic [39:0] i_lcd_seg,
    input wire pin_mux_pkg::timer_out_s i_timer_out,
    input wire logic i_uart_tx,
    // Port data drivers
    input wire logic [31:0] i_gpio_out_eh,
    input wire logic [31:0] i_gpio_oe_eh,
    input wire logic [3:0] i_gpio_out_pb_hi,
    input wire logic [3:0] i_gpio_oe_pb_hi,
    input wire logic i_gpio_out_pa4,
    input wire logic i_gpio_oe_pa4,
    // Pad drive
    output logic [31:0] o_pad_out_eh,
    output logic [31:0] o_pad_oe_eh,
    output logic [3:0] o_pad_out_pb_hi,
    output logic [3:0] o_pad_oe_pb_hi,
    output logic o_pad_out_pa4,
    output logic o_pad_oe_pa4,
    output logic [7:0] o_pd_drive,
    // Routed peripheral inputs and analog switches
    output pin_mux_pkg::periph_in_s o_periph_in,
    output pin_mux_pkg::analog_en_s o_analog_en
);

    localparam logic IS_REDUCED =
        (VARIANT == pin_mux_pkg::VARIANT_REDUCED);
    localparam logic IS_SMALLEST =
        (VARIANT == pin_mux_pkg::VARIANT_SMALLEST);
    localparam logic IS_SINGLE =
        (VARIANT == pin_mux_pkg::VARIANT_SINGLE_BIT);
    localparam logic [7:0] PORT_H_MASK = IS_REDUCED ?
        pin_mux_pkg::MASK_PORT_H_REDUCED : pin_mux_pkg::MASK_ALL;
    localparam logic [7:0] SPECIAL_TWO_MASK = IS_SINGLE ?
        pin_mux_pkg::MASK_SPECIAL_TWO_SINGLE :
        pin_mux_pkg::MASK_SPECIAL_TWO;
    localparam logic [7:0] PORT_H_RST =
        pin_mux_pkg::RST_PORT_FS & PORT_H_MASK;

    // Registers
    logic [7:0] port_e_function_select_ff;
    logic [7:0] port_f_function_select_ff;
    logic [7:0] port_g_function_select_ff;
    logic [7:0] port_h_function_select_ff;
    logic [7:0] special_route_select_ff;
    logic [7:0] special_route_select_two_ff;
    logic [7:0] port_b_function_select_ff;

    // Pad synchroniser stages
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] sync3_ff;
    logic [7:0] pad_filt_ff;
    logic [7:0] nxt_pad_filt;
    pin_mux_pkg::pad_in_s pad;

    // Bus decode
    logic hit_e;
    logic hit_f;
    logic hit_g;
    logic hit_h;
    logic hit_sp;
    logic hit_sp2;
    logic hit_b;
    logic hit_any;
    logic setup_phase;
    logic wr_go;
    logic [7:0] wdata;
    logic [7:0] rd_byte;

    assign hit_e = (i_paddr == pin_mux_pkg::OFS_PORT_E);
    assign hit_f = (i_paddr == pin_mux_pkg::OFS_PORT_F);
    assign hit_g = (i_paddr == pin_mux_pkg::OFS_PORT_G);
    assign hit_h = (i_paddr == pin_mux_pkg::OFS_PORT_H);
    assign hit_sp = (i_paddr == pin_mux_pkg::OFS_SPECIAL);
    assign hit_sp2 = (i_paddr == pin_mux_pkg::OFS_SPECIAL_TWO);
    assign hit_b = (i_paddr == pin_mux_pkg::OFS_PORT_B);
    assign hit_any = hit_e | hit_f | hit_g | hit_h | hit_sp | hit_sp2
        | hit_b;
    assign setup_phase = i_psel & ~i_penable;
    assign wr_go = i_psel & i_penable & i_pwrite & o_pready;
    assign wdata = i_pwdata[7:0];

    assign rd_byte = hit_e ? port_e_function_select_ff :
        hit_f ? port_f_function_select_ff :
        hit_g ? port_g_function_select_ff :
        hit_h ? port_h_function_select_ff :
        hit_sp ? special_route_select_ff :
        hit_sp2 ? special_route_select_two_ff :
        hit_b ? port_b_function_select_ff : 8'h00;

    // APB answer one cycle after setup
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup_phase) begin
            o_pready <= 1'b1;
            o_prdata <= {24'h00_0000, rd_byte};
            o_pslverr <= ~hit_any;
        end else begin
            o_pready <= 1'b0;
        end
    end

    // Register next values
    logic [7:0] nxt_port_e;
    logic [7:0] nxt_port_f;
    logic [7:0] nxt_port_g;
    logic [7:0] nxt_port_h;
    logic [7:0] nxt_special;
    logic [7:0] nxt_special_two;
    logic [7:0] nxt_port_b;

    assign nxt_port_e = (wr_go & hit_e) ? wdata : port_e_function_select_ff;
    assign nxt_port_f = (wr_go & hit_f) ? wdata : port_f_function_select_ff;
    assign nxt_port_g = (wr_go & hit_g) ? wdata : port_g_function_select_ff;
    assign nxt_port_h = ((wr_go & hit_h) ? wdata : port_h_function_select_ff)
        & PORT_H_MASK;
    assign nxt_special = (wr_go & hit_sp) ? wdata : special_route_select_ff;
    assign nxt_special_two = ((wr_go & hit_sp2) ? wdata
        : special_route_select_two_ff) & SPECIAL_TWO_MASK;
    assign nxt_port_b = ((wr_go & hit_b) ? wdata : port_b_function_select_ff)
        & pin_mux_pkg::MASK_PORT_B;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            port_e_function_select_ff <= pin_mux_pkg::RST_PORT_FS;
            port_f_function_select_ff <= pin_mux_pkg::RST_PORT_FS;
            port_g_function_select_ff <= pin_mux_pkg::RST_PORT_FS;
            port_h_function_select_ff <= PORT_H_RST;
        end else begin
            port_e_function_select_ff <= nxt_port_e;
            port_f_function_select_ff <= nxt_port_f;
            port_g_function_select_ff <= nxt_port_g;
            port_h_function_select_ff <= nxt_port_h;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            special_route_select_ff <= pin_mux_pkg::RST_SPECIAL;
            special_route_select_two_ff <= pin_mux_pkg::RST_SPECIAL_TWO;
            port_b_function_select_ff <= pin_mux_pkg::RST_PORT_B;
        end else begin
            special_route_select_ff <= nxt_special;
            special_route_select_two_ff <= nxt_special_two;
            port_b_function_select_ff <= nxt_port_b;
        end
    end

    // Pad inputs: three stages, change taken when stages two and three agree
    assign nxt_pad_filt = (~(sync2_ff ^ sync3_ff) & sync3_ff)
        | ((sync2_ff ^ sync3_ff) & pad_filt_ff);
    assign pad = pad_filt_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            sync3_ff <= 8'h00;
            pad_filt_ff <= 8'h00;
        end else begin
            sync1_ff <= i_pad_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pad_filt_ff <= nxt_pad_filt;
        end
    end

    // Ports E to H: segment or GPIO per bit
    logic [31:0] sel_eh;
    logic [31:0] nxt_pad_out_eh;
    logic [31:0] nxt_pad_oe_eh;

    assign sel_eh = {port_h_function_select_ff, port_g_function_select_ff,
        port_f_function_select_ff, port_e_function_select_ff};

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_seg
            assign nxt_pad_out_eh[gi] = sel_eh[gi] ? i_lcd_seg[gi + 8]
                : i_gpio_out_eh[gi];
            assign nxt_pad_oe_eh[gi] = sel_eh[gi] | i_gpio_oe_eh[gi];
        end
    endgenerate

    // Port D special functions
    logic [3:0] pd_timer;
    logic [7:0] nxt_pd_drive;

    assign pd_timer = {i_timer_out.periodic_timer1_out_inv,
        i_timer_out.periodic_timer1_out,
        i_timer_out.periodic_timer0_out_inv,
        i_timer_out.periodic_timer0_out};
    assign nxt_pd_drive[7:4] = (special_route_select_ff[3:0] & pd_timer)
        | (~special_route_select_ff[3:0] & i_lcd_seg[7:4]);
    assign nxt_pd_drive[3] = i_lcd_seg[3];
    assign nxt_pd_drive[2] = (IS_SMALLEST
        & special_route_select_ff[pin_mux_pkg::STD_TIMER_CLK_ROUTE_BIT])
        ? i_timer_out.compact_timer_out_two : i_lcd_seg[2];
    assign nxt_pd_drive[1:0] = i_lcd_seg[1:0];

    // Port B upper lines: two-bit codes
    logic [1:0] pb4_code;
    logic [1:0] pb5_code;
    logic [1:0] pb6_code;
    logic [1:0] pb7_code;
    logic [3:0] nxt_pb_out;
    logic [3:0] nxt_pb_oe;
    logic [1:0] analog_off;

    assign pb4_code = {special_route_select_two_ff[
        pin_mux_pkg::PORTB_LINE4_HIGH_SELECT],
        port_b_function_select_ff[4]};
    assign pb5_code = {special_route_select_two_ff[
        pin_mux_pkg::PORTB_LINE5_HIGH_SELECT],
        port_b_function_select_ff[5]};
    assign pb6_code = {port_b_function_select_ff[6],
        special_route_select_two_ff[
        pin_mux_pkg::PORTB_LINE6_LOW_SELECT]};
    assign pb7_code = {port_b_function_select_ff[7],
        special_route_select_two_ff[
        pin_mux_pkg::PORTB_LINE7_LOW_SELECT]};
    assign analog_off = IS_SINGLE ? 2'b11 : 2'b00;

    // PB4
    assign nxt_pb_out[0] = (pb4_code == 2'b01)
        ? i_timer_out.periodic_timer0_out
        : (pb4_code == 2'b10) ? 1'b0 : i_gpio_out_pb_hi[0];
    assign nxt_pb_oe[0] = (pb4_code == 2'b01) ? 1'b1
        : (pb4_code == 2'b10) ? 1'b0 : i_gpio_oe_pb_hi[0];
    // PB5
    assign nxt_pb_out[1] = (pb5_code == 2'b01)
        ? i_timer_out.periodic_timer0_out_inv
        : (pb5_code == 2'b00) ? i_gpio_out_pb_hi[1] : 1'b0;
    assign nxt_pb_oe[1] = (pb5_code == 2'b01) ? 1'b1
        : (pb5_code == 2'b00) ? i_gpio_oe_pb_hi[1] : 1'b0;
    // PB6: 11 is the UART receive input
    assign nxt_pb_out[2] = (pb6_code == 2'b10)
        ? i_timer_out.periodic_timer1_out
        : (pb6_code == 2'b00 || (pb6_code == 2'b01 && analog_off[0]))
        ? i_gpio_out_pb_hi[2] : 1'b0;
    assign nxt_pb_oe[2] = (pb6_code == 2'b10) ? 1'b1
        : (pb6_code == 2'b00 || (pb6_code == 2'b01 && analog_off[0]))
        ? i_gpio_oe_pb_hi[2] : 1'b0;
    // PB7
    assign nxt_pb_out[3] = (pb7_code == 2'b10)
        ? i_timer_out.periodic_timer1_out_inv
        : (pb7_code == 2'b11) ? i_uart_tx
        : (pb7_code == 2'b00 || analog_off[1])
        ? i_gpio_out_pb_hi[3] : 1'b0;
    assign nxt_pb_oe[3] = (pb7_code == 2'b10 || pb7_code == 2'b11) ? 1'b1
        : (pb7_code == 2'b00 || analog_off[1])
        ? i_gpio_oe_pb_hi[3] : 1'b0;

    // PA4 and analog switches
    logic pa4_analog;
    pin_mux_pkg::analog_en_s nxt_analog;

    assign pa4_analog =
        special_route_select_two_ff[pin_mux_pkg::PORTA_LINE4_SELECT];
    assign nxt_analog.analog_input_five = pa4_analog;
    assign nxt_analog.analog_input_zero = (pb5_code == 2'b11);
    assign nxt_analog.analog_input_one = (pb6_code == 2'b01) & ~IS_SINGLE;
    assign nxt_analog.analog_input_two = (pb7_code == 2'b01) & ~IS_SINGLE;
    assign nxt_analog.adc_reference_input = (pb4_code == 2'b10);
    assign nxt_analog.adc_reference_output = (pb5_code == 2'b10);

    // Peripheral input routing
    pin_mux_pkg::periph_in_s nxt_periph;

    assign nxt_periph.standard_timer_ext_clock = (~IS_SMALLEST
        & special_route_select_ff[pin_mux_pkg::STD_TIMER_CLK_ROUTE_BIT])
        ? pad.pd2 : pad.pa2;
    assign nxt_periph.periodic_timer0_ext_clock =
        special_route_select_ff[pin_mux_pkg::PTIMER0_CLK_ROUTE_BIT]
        ? pad.pd3 : pad.pa0;
    assign nxt_periph.compact_timer_ext_clock =
        special_route_select_ff[pin_mux_pkg::COMPACT_TIMER_CLK_ROUTE_BIT]
        ? pad.pd1 : pad.pa2;
    assign nxt_periph.external_irq_line_one =
        special_route_select_ff[pin_mux_pkg::EXT_IRQ1_ROUTE_BIT]
        ? pad.pd0 : pad.pa0;
    assign nxt_periph.periodic_timer1_ext_clock =
        special_route_select_two_ff[pin_mux_pkg::PTIMER1_CLK_ROUTE_BIT]
        ? pad.pd0 : pad.pa4;
    assign nxt_periph.external_irq_line_zero = pa4_analog ? 1'b0
        : pad.pa4;
    assign nxt_periph.uart_rx = (pb6_code == 2'b11) ? pad.pb6 : 1'b1;

    // Registered pin-side outputs
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pad_out_eh <= 32'h0000_0000;
            o_pad_oe_eh <= 32'h0000_0000;
            o_pd_drive <= 8'h00;
        end else begin
            o_pad_out_eh <= nxt_pad_out_eh;
            o_pad_oe_eh <= nxt_pad_oe_eh;
            o_pd_drive <= nxt_pd_drive;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pad_out_pb_hi <= 4'h0;
            o_pad_oe_pb_hi <= 4'h0;
            o_pad_out_pa4 <= 1'b0;
            o_pad_oe_pa4 <= 1'b0;
        end else begin
            o_pad_out_pb_hi <= nxt_pb_out;
            o_pad_oe_pb_hi <= nxt_pb_oe;
            o_pad_out_pa4 <= pa4_analog ? 1'b0 : i_gpio_out_pa4;
            o_pad_oe_pa4 <= pa4_analog ? 1'b0 : i_gpio_oe_pa4;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_periph_in <= 7'h01;
            o_analog_en <= 6'h00;
        end else begin
            o_periph_in <= nxt_periph;
            o_analog_en <= nxt_analog;
        end
    end

endmodule

`default_nettype wire

// [pin_mux_properties.sv]
// Checker for the pin-function mux, bound to its top module.
// Assumes the full variant and answers one cycle after setup.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_properties (
    // Clock, reset and bus
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Pins
    input wire logic [39:0] i_lcd_seg,
    input wire logic [31:0] i_gpio_out_eh,
    input wire logic [31:0] i_gpio_oe_eh,
    input wire logic [31:0] o_pad_out_eh,
    input wire logic [31:0] o_pad_oe_eh,
    input wire logic [7:0] o_pd_drive
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic setup_ff;
    logic live_ff;
    wire setup = i_psel && !i_penable;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            setup_ff <= 1'b0;
            live_ff <= 1'b0;
        end else begin
            setup_ff <= setup;
            live_ff <= 1'b1;
        end
    end
    a_ready_after_setup: assert property (
        setup |=> o_pready) else $error("no ready after setup");
    a_ready_one_pulse: assert property (
        o_pready |=> !o_pready) else $error("ready longer than one cycle");
    a_unmapped_reads_zero: assert property (
        setup && i_paddr > 12'h018 |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_route_two_top: assert property (
        setup && !i_pwrite && i_paddr == 12'h014 |=> o_prdata[7:6] == 2'h0)
        else $error("route two upper bits not zero");
    a_rdata_upper_zero: assert property (
        o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits");
    a_rdata_holds: assert property (
        live_ff && !setup_ff |-> $stable(o_prdata))
        else $error("read data moved");
    a_pd_low_segments: assert property (
        live_ff |-> o_pd_drive[3:0] == $past(i_lcd_seg[3:0]))
        else $error("port d low lines not segments");
    a_eh_pin_source: assert property (
        live_ff |-> &((~(o_pad_out_eh ^ $past(i_lcd_seg[39:8])) & o_pad_oe_eh)
        | (~(o_pad_out_eh ^ $past(i_gpio_out_eh))
        & ~(o_pad_oe_eh ^ $past(i_gpio_oe_eh)))))
        else $error("port pin neither segment nor port");
    a_port_e_write: assert property (
        setup && i_pwrite && i_paddr == 12'h000 |-> ##3 o_pad_oe_eh[7:0]
        == ($past(i_pwdata[7:0], 3) | $past(i_gpio_oe_eh[7:0])))
        else $error("port e selection not applied");
    c_write_e: cover property (setup && i_pwrite && i_paddr == 12'h000);
    c_unmapped: cover property (o_pready && o_pslverr);
    c_read_two: cover property (setup && !i_pwrite && i_paddr == 12'h014);
endmodule
bind pin_function_select_mux pin_mux_properties u_props (.*);
`default_nettype wire

// [pad_partner.sv]
// Pad and peripheral model driving the far-side inputs of the mux.
// Assumes the bench holds it still while results are compared.
`timescale 1ns/1ps
`default_nettype none
module pad_partner #(
    parameter logic [39:0] SEG_V = 40'h0,
    parameter logic [4:0] TMR_V = 5'h00,
    parameter logic [7:0] PAD_V = 8'h00
) (
    // Clock and control
    input wire logic i_clock,
    input wire logic i_hold,
    // Levels seen by the mux
    output pin_mux_pkg::pad_in_s o_pad,
    output logic [39:0] o_seg,
    output pin_mux_pkg::timer_out_s o_tmr,
    output logic o_tx
);
    logic flip_ff = 1'b0;
    // Toggles every cycle unless held
    always @(posedge i_clock) begin
        flip_ff <= !i_hold && !flip_ff;
    end
    assign o_pad = PAD_V ^ {8{flip_ff}};
    assign o_seg = SEG_V ^ {40{flip_ff}};
    assign o_tmr = TMR_V ^ {5{flip_ff}};
    assign o_tx = !flip_ff;
endmodule
`default_nettype wire

// [tb_pin_function_select_mux.sv]
// Testbench for the pin-function mux: registers and routing.
// Assumes full and single-bit variants on one bus and the pad partner.
`timescale 1ns/1ps
`default_nettype none
module tb_pin_function_select_mux;
    localparam logic [39:0] SEG_V = 40'h5AC3963C4E;
    localparam logic [4:0] TMR_V = 5'h16;
    localparam logic [7:0] PAD_V = 8'h35;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] i_gpio_out_eh = 32'hA53C69C3;
    logic [31:0] i_gpio_oe_eh = 32'h0F0F0F0F;
    logic [3:0] i_gpio_out_pb_hi = 4'h6;
    logic [3:0] i_gpio_oe_pb_hi = 4'hF;
    logic i_gpio_oe_pa4 = 1'b1;
    logic hold = 1'b0;
    wire i_gpio_out_pa4 = hold;
    pin_mux_pkg::pad_in_s i_pad_in;
    pin_mux_pkg::timer_out_s i_timer_out;
    logic [39:0] i_lcd_seg;
    logic i_uart_tx;
    logic [31:0] o_prdata, o_pad_out_eh, o_pad_oe_eh;
    logic [3:0] o_pad_out_pb_hi, o_pad_oe_pb_hi;
    logic o_pready, o_pslverr, o_pad_out_pa4, o_pad_oe_pa4;
    logic [7:0] o_pd_drive;
    pin_mux_pkg::periph_in_s o_periph_in;
    pin_mux_pkg::analog_en_s o_analog_en;
    logic [3:0] s_out_pb, s_oe_pb;
    pin_mux_pkg::analog_en_s s_analog;
    int err_count = 0;
    int total_checks = 0;
    logic [7:0] rd;
    logic err;
    // Address, reset value, write data, read-back value
    logic [35:0] regs [8] = '{{12'h000, 8'hFF, 8'h5A, 8'h5A},
        {12'h004, 8'hFF, 8'h3C, 8'h3C}, {12'h008, 8'hFF, 8'hC3, 8'hC3},
        {12'h00C, 8'hFF, 8'h96, 8'h96}, {12'h010, 8'h00, 8'hFF, 8'hFF},
        {12'h014, 8'h00, 8'hFF, 8'h3F}, {12'h018, 8'h00, 8'hFF, 8'hF0},
        {12'h01C, 8'h00, 8'hFF, 8'h00}};
    // Route, route two, port b; port d, inputs, analog, pb pins, pa4
    logic [54:0] rt [4] = '{
        {8'h00, 8'h00, 8'h00, 8'h4E, 7'h37, 6'h00, 4'h6, 4'hF, 2'h3},
        {8'hFF, 8'hFF, 8'hF0, 8'hBE, 7'h48, 6'h30, 4'h8, 4'h9, 2'h0},
        {8'h00, 8'h12, 8'hA0, 8'h4E, 7'h37, 6'h0A, 4'hA, 4'hA, 2'h3},
        {8'h5A, 8'h0C, 8'h50, 8'hEE, 7'h13, 6'h05, 4'h1, 4'h5, 2'h3}};
    pin_function_select_mux dut (.*);
    pin_function_select_mux #(
        .VARIANT(pin_mux_pkg::VARIANT_SINGLE_BIT)
    ) dut_single (
        .*, .o_prdata(), .o_pready(), .o_pslverr(), .o_pad_out_eh(),
        .o_pad_oe_eh(), .o_pad_out_pb_hi(s_out_pb),
        .o_pad_oe_pb_hi(s_oe_pb), .o_pad_out_pa4(), .o_pad_oe_pa4(),
        .o_pd_drive(), .o_periph_in(), .o_analog_en(s_analog));
    pad_partner #(.SEG_V(SEG_V), .TMR_V(TMR_V), .PAD_V(PAD_V)) u_partner (
        .i_clock(i_clock), .i_hold(hold), .o_pad(i_pad_in),
        .o_seg(i_lcd_seg), .o_tmr(i_timer_out), .o_tx(i_uart_tx));
    always #50 i_clock = ~i_clock;
    task automatic check(input string name, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= 32'(d);
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        if (o_pready !== 1'b1) begin
            err_count++;
        end
        rd = o_prdata[7:0];
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic test_done;
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge i_clock);
        err_count++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (10) @(posedge i_clock);
        hold <= 1'b1;
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        check("reset pins", o_pad_out_eh, SEG_V[39:8]);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, regs[i][35:24], 8'h00);
            check("reset value", 32'(rd), 32'(regs[i][23:16]));
            apb(1'b1, regs[i][35:24], regs[i][15:8]);
            apb(1'b0, regs[i][35:24], 8'h00);
            check("read back", 32'(rd), 32'(regs[i][7:0]));
            check("bus error", 32'(err), 32'(i == 7));
        end
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        check("port pins", o_pad_out_eh, (32'h96C33C5A & SEG_V[39:8])
            | (~32'h96C33C5A & i_gpio_out_eh));
        check("port enables", o_pad_oe_eh,
            32'h96C33C5A | i_gpio_oe_eh);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h010, rt[i][54:47]);
            apb(1'b1, 12'h014, rt[i][46:39]);
            apb(1'b1, 12'h018, rt[i][38:31]);
            repeat (8) @(posedge i_clock);
            @(negedge i_clock);
            check("port d", 32'(o_pd_drive), 32'(rt[i][30:23]));
            check("inputs", 32'(o_periph_in),
                32'(rt[i][22:16]));
            check("analog", 32'(o_analog_en),
                32'(rt[i][15:10]));
            check("pb pins", 32'({o_pad_out_pb_hi, o_pad_oe_pb_hi}),
                32'(rt[i][9:2]));
            check("pa4 pin", 32'({o_pad_out_pa4, o_pad_oe_pa4}),
                32'(rt[i][1:0]));
        end
        check("single pb", 32'({s_out_pb, s_oe_pb}), 32'h3F);
        check("single analog", 32'(s_analog), 32'h0);
        @(posedge i_clock);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_resetn <= 1'b1;
        apb(1'b0, 12'h018, 8'h00);
        check("port b after reset", 32'(rd), 32'h0);
        @(negedge i_clock);
        check("reset oe", o_pad_oe_eh, 32'hFFFFFFFF);
        test_done;
    end
endmodule
`default_nettype wire
